// file: dv/adc_channel_pin_control_test.sv
// Self-checking testbench for the converter channel and pin control block.
`timescale 1ns/1ns
module adc_channel_pin_control_test;
  typedef struct packed {logic rd; logic [7:0] data; logic err;} acpc_note_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [11:0] conv_data = 12'h000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [4:0] analog_route;
  logic [4:0] port_digital_en;
  logic ext_ref_route;
  logic [1:0] int_ref_level;
  logic conv_power;
  logic conv_sample;
  logic irq;
  logic [15:0] irq_vector;
  acpc_note_t notes[$];
  acpc_note_t note;
  int fail_count = 0;
  int n_checks = 0;
  int seed;
  int l;
  int c;
  int i;
  int n;
  int k_exp;
  int divs[4] = '{16, 8, 1, 2};
  logic [4:0] v;
  logic [1:0] code;
  logic res;
  logic m;
  logic seen;
  logic [2:0] ch;
  logic [11:0] data;

  acpc_top i_acpc_top (.core_clk_in(core_clk), .rst_in(rst), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .conv_data_in(conv_data), .analog_route_out(analog_route),
    .port_digital_en_out(port_digital_en), .ext_ref_route_out(ext_ref_route),
    .int_ref_level_out(int_ref_level), .conv_power_out(conv_power), .conv_sample_out(conv_sample),
    .irq_out(irq), .irq_vector_out(irq_vector));

  always #4 core_clk = ~core_clk;

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask

  task automatic tally_and_finish;
    if (fail_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One idle cycle separates transfers so no strobe is assigned twice in a time step.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [7:0] exp,
                     input logic err);
    int k;
    @(posedge core_clk);
    notes.push_back('{rd: !wr, data: exp, err: err});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge core_clk);
      if (pready === 1'b1)
        break;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20)
    begin
      fail_count++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 8'h00, 1'b0);
    repeat (2) @(posedge core_clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00, exp, 1'b0);
  endtask

  always @(posedge core_clk)
  begin
    if (pready === 1'b1)
    begin
      if (notes.size() == 0)
        check("unexpected answer", 16'h0001, 16'h0000);
      else
      begin
        note = notes.pop_front();
        check("pslverr", {15'h0000, note.err}, {15'h0000, pslverr});
        if (note.rd)
          check("prdata", {8'h00, note.data}, prdata[15:0]);
      end
    end
  end

  initial
  begin
    seed = 32'h0721;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    check("digital_en reset", 16'h001F, {11'h000, port_digital_en});
    check("route reset", 16'h0000, {11'h000, analog_route});
    v = 5'($random(seed));
    wr(acpc_pkg::ADDR_ANALOG_ONLY, {3'h0, v});
    check("digital_en", {11'h000, ~v}, {11'h000, port_digital_en});
    rd(acpc_pkg::ADDR_ANALOG_ONLY, 8'h00);
    for (l = 0; l < 4; l++)
    begin
      wr(acpc_pkg::ADDR_REF, {l[0], 5'h00, l[1:0]});
      check("int_ref_level", 16'(l), {14'h0000, int_ref_level});
      check("ext_ref_route", 16'(l[0]), {15'h0000, ext_ref_route});
      rd(acpc_pkg::ADDR_REF, {l[0], 5'h00, l[1:0]});
    end
    // Pin 0 carries the reference now, so it must not be routed as an input.
    wr(acpc_pkg::ADDR_MODE, 8'h10);
    check("route ext ref", 16'h0000, {11'h000, analog_route});
    wr(acpc_pkg::ADDR_REF, 8'h02);
    for (c = 0; c < 8; c++)
    begin
      wr(acpc_pkg::ADDR_MODE, {5'h00, 3'(c)});
      check("route no connect", 16'h0000, {11'h000, analog_route});
      wr(acpc_pkg::ADDR_MODE, {5'h02, 3'(c)});
      check("route", 16'(c < 5 ? (1 << c) : 0), {11'h000, analog_route});
    end
    apb(1'b0, 12'h000, 8'h00, 8'h00, 1'b1);
    wr(acpc_pkg::ADDR_ANALOG_ONLY, 8'h1F);
    wr(acpc_pkg::ADDR_MODE, 8'h80);
    check("conv_power on", 16'h0001, {15'h0000, conv_power});
    // Firmware owes the converter its warm-up once per power enable: 12500 cycles of 8 ns.
    repeat (12500) @(posedge core_clk);
    for (i = 0; i < 8; i++)
    begin
      code = 2'(i);
      res = i[2];
      m = i[1] ^ i[2];
      ch = 3'(i % 5);
      data = 12'($random(seed));
      k_exp = divs[code] * 4 * (res ? 16 : 12);
      conv_data <= data;
      wr(acpc_pkg::ADDR_RESULT_LOW, {1'b0, code[1], res, code[0], 4'h0});
      wr(acpc_pkg::ADDR_IRQ_MASK, {7'h00, m});
      apb(1'b1, acpc_pkg::ADDR_MODE, 8'hD0 | ch, 8'h00, 1'b0);
      seen = 1'b0;
      for (n = 1; n <= k_exp + 3; n++)
      begin
        @(posedge core_clk);
        if (irq === 1'b1)
        begin
          seen = 1'b1;
          break;
        end
      end
      check("irq_out", {15'h0000, m}, {15'h0000, seen});
      if (m)
        check("conversion time", 16'(k_exp + 3), 16'(n));
      check("irq_vector", m ? 16'h0008 : 16'h0000, irq_vector);
      rd(acpc_pkg::ADDR_MODE, 8'hB0 | ch);
      rd(acpc_pkg::ADDR_RESULT_HIGH, data[11:4]);
      rd(acpc_pkg::ADDR_RESULT_LOW, {1'b0, code[1], res, code[0], data[3:0]});
      rd(acpc_pkg::ADDR_IRQ_STATUS, 8'h01);
      rd(acpc_pkg::ADDR_IRQ_STATUS, 8'h00);
      check("irq_out cleared", 16'h0000, {15'h0000, irq});
      apb(1'b1, acpc_pkg::ADDR_MODE, 8'hD0 | ch, 8'h00, 1'b0);
      rd(acpc_pkg::ADDR_MODE, 8'hD0 | ch);
      check("sample running", 16'h0001, {15'h0000, conv_sample});
      wr(acpc_pkg::ADDR_MODE, {5'h12, 3'((ch + 1) % 5)});
      check("route held", 16'(1 << ch), {11'h000, analog_route});
      repeat (k_exp + 4) @(posedge core_clk);
      rd(acpc_pkg::ADDR_IRQ_STATUS, 8'h01);
      check("sample idle", 16'h0000, {15'h0000, conv_sample});
    end
    wr(acpc_pkg::ADDR_MODE, 8'h00);
    check("conv_power off", 16'h0000, {15'h0000, conv_power});
    tally_and_finish();
  end
endmodule // adc_channel_pin_control_test

// file: logic/acpc_conv_seq.sv
// Conversion sequencer: divides the core clock into converter steps and counts a whole conversion.
`timescale 1ns/1ns
module acpc_conv_seq (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic [1:0] clk_div_in,
  input wire logic res12_in,
  output logic busy_out,
  output logic done_out
);

  acpc_pkg::acpc_seq_state_t state_q;
  acpc_pkg::acpc_seq_state_t state_d;
  logic [6:0] step_q;
  logic [6:0] step_d;
  logic [4:0] count_q;
  logic [4:0] count_d;
  logic [6:0] step_lim_q;
  logic [6:0] step_lim_d;
  logic [4:0] count_lim_q;
  logic [4:0] count_lim_d;
  logic done_q;
  logic done_d;

  // Divider and resolution are frozen at start so a mid-conversion write cannot stretch it.
  always_comb
  begin
    state_d = state_q;
    step_d = step_q;
    count_d = count_q;
    step_lim_d = step_lim_q;
    count_lim_d = count_lim_q;
    done_d = 1'b0;
    case (state_q)
      acpc_pkg::SEQ_IDLE:
      begin
        if (start_in)
        begin
          state_d = acpc_pkg::SEQ_CONV;
          step_d = 7'h00;
          count_d = 5'h00;
          step_lim_d = acpc_pkg::step_limit(clk_div_in);
          count_lim_d = acpc_pkg::steps_limit(res12_in);
        end
      end
      acpc_pkg::SEQ_CONV:
      begin
        step_d = 7'(step_q + 7'h01);
        if (step_q == step_lim_q)
        begin
          step_d = 7'h00;
          count_d = 5'(count_q + 5'h01);
          if (count_q == count_lim_q)
          begin
            state_d = acpc_pkg::SEQ_IDLE;
            done_d = 1'b1;
          end
        end
      end
      default:
      begin
        state_d = acpc_pkg::SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_q <= acpc_pkg::SEQ_IDLE;
      step_q <= 7'h00;
      count_q <= 5'h00;
      step_lim_q <= 7'h00;
      count_lim_q <= 5'h00;
      done_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      step_q <= step_d;
      count_q <= count_d;
      step_lim_q <= step_lim_d;
      count_lim_q <= count_lim_d;
      done_q <= done_d;
    end
  end

  assign busy_out = (state_q == acpc_pkg::SEQ_CONV);
  assign done_out = done_q;

  a_done_single: assert property (@(posedge core_clk_in) disable iff (rst_in)
    done_q |=> !done_q)
    else $error("Conversion done pulse lasted more than one cycle.");

endmodule // acpc_conv_seq

// file: logic/acpc_pkg.sv
// Shared constants, register map and conversion timing for the converter channel and pin control block.
package acpc_pkg;

  // Register indices; the APB byte address is four times the index.
  localparam logic [7:0] IDX_ANALOG_ONLY = 8'hAE;
  localparam logic [7:0] IDX_REF = 8'hAF;
  localparam logic [7:0] IDX_MODE = 8'hB0;
  localparam logic [7:0] IDX_RESULT_HIGH = 8'hB1;
  localparam logic [7:0] IDX_RESULT_LOW = 8'hB2;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hB3;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hB4;

  localparam int unsigned APB_AW = 12;
  localparam logic [APB_AW-1:0] ADDR_ANALOG_ONLY = {2'h0, IDX_ANALOG_ONLY, 2'h0};
  localparam logic [APB_AW-1:0] ADDR_REF = {2'h0, IDX_REF, 2'h0};
  localparam logic [APB_AW-1:0] ADDR_MODE = {2'h0, IDX_MODE, 2'h0};
  localparam logic [APB_AW-1:0] ADDR_RESULT_HIGH = {2'h0, IDX_RESULT_HIGH, 2'h0};
  localparam logic [APB_AW-1:0] ADDR_RESULT_LOW = {2'h0, IDX_RESULT_LOW, 2'h0};
  localparam logic [APB_AW-1:0] ADDR_IRQ_STATUS = {2'h0, IDX_IRQ_STATUS, 2'h0};
  localparam logic [APB_AW-1:0] ADDR_IRQ_MASK = {2'h0, IDX_IRQ_MASK, 2'h0};

  // Mode register fields.
  localparam int unsigned MODE_POWER_BIT = 7;
  localparam int unsigned MODE_START_BIT = 6;
  localparam int unsigned MODE_EOC_BIT = 5;
  localparam int unsigned MODE_CONNECT_BIT = 4;
  localparam int unsigned MODE_CHSEL_MSB = 2;
  localparam int unsigned MODE_CHSEL_LSB = 0;
  // Result-low register fields.
  localparam int unsigned LOW_DIV1_BIT = 6;
  localparam int unsigned LOW_RES_BIT = 5;
  localparam int unsigned LOW_DIV0_BIT = 4;
  localparam int unsigned LOW_NIB_MSB = 3;
  // Reference register fields.
  localparam int unsigned REF_EXT_BIT = 7;
  localparam int unsigned REF_LEVEL_MSB = 1;
  // Interrupt status and mask field.
  localparam int unsigned IRQ_CONV_BIT = 0;

  localparam int unsigned PIN_COUNT = 5;
  localparam int unsigned CHSEL_W = 3;
  localparam int unsigned RESULT_W = 12;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] IRQ_VECTOR = 16'h0008;
  localparam logic RES_12BIT = 1'b1;

  // Converter clock dividers: code 00 is /16, 01 is /8, 10 is /1, 11 is /2.
  localparam logic [1:0] DIV_CODE_16 = 2'h0;
  localparam logic [1:0] DIV_CODE_8 = 2'h1;
  localparam logic [1:0] DIV_CODE_1 = 2'h2;
  localparam logic [1:0] DIV_CODE_2 = 2'h3;
  // Core cycles per converter step minus one: divider times four.
  localparam logic [6:0] STEP_LIM_16 = 7'h3F;
  localparam logic [6:0] STEP_LIM_8 = 7'h1F;
  localparam logic [6:0] STEP_LIM_1 = 7'h03;
  localparam logic [6:0] STEP_LIM_2 = 7'h07;
  // Steps per conversion minus one: 16 steps at 12 bits, 12 steps at 8 bits.
  localparam logic [4:0] STEPS_LIM_12 = 5'h0F;
  localparam logic [4:0] STEPS_LIM_8 = 5'h0B;

  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_CONV = 1'b1
  } acpc_seq_state_t;

  function automatic logic [6:0] step_limit(input logic [1:0] code);
    logic [6:0] lim;
    case (code)
      DIV_CODE_16: lim = STEP_LIM_16;
      DIV_CODE_8: lim = STEP_LIM_8;
      DIV_CODE_1: lim = STEP_LIM_1;
      default: lim = STEP_LIM_2;
    endcase
    return lim;
  endfunction

  function automatic logic [4:0] steps_limit(input logic res12);
    return res12 ? STEPS_LIM_12 : STEPS_LIM_8;
  endfunction

  function automatic logic [10:0] conv_cycles(input logic [1:0] code, input logic res12);
    logic [10:0] a;
    logic [10:0] b;
    a = {4'h0, step_limit(code)} + 11'h001;
    b = {6'h00, steps_limit(res12)} + 11'h001;
    return 11'(a * b);
  endfunction

endpackage

// file: logic/acpc_top.sv
// Converter channel selection, pin configuration, conversion control and APB registers.
//
// Contract
// - Channel field value selects analog input directly.
// - At most one pin routed to converter.
// - Channel connects only after connect enable set.
// - Analog-only bit 1 disables pin digital function.
// - Analog-only bit 0 keeps pin dual purpose.
// - Analog-only bits 4:0 map pins, write-only, reset 0.
// - External reference enable makes pin 0 reference.
// - Start bit clears itself at conversion end.
// - End flag clears when start written one.
// - Conversion end sets interrupt flag, vector 8.
// - Result high byte and low nibble split.
// - Conversion lasts 16 or 12 steps of four divided-clock periods.
// - Reference level field picks supply, 4V, 3V, 2V.
`timescale 1ns/1ns
module acpc_top #(
  parameter int unsigned NUM_PINS = acpc_pkg::PIN_COUNT
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [acpc_pkg::APB_AW-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [acpc_pkg::RESULT_W-1:0] conv_data_in,
  output logic [NUM_PINS-1:0] analog_route_out,
  output logic [NUM_PINS-1:0] port_digital_en_out,
  output logic ext_ref_route_out,
  output logic [1:0] int_ref_level_out,
  output logic conv_power_out,
  output logic conv_sample_out,
  output logic irq_out,
  output logic [15:0] irq_vector_out
);

  function automatic logic addr_hit(input logic [acpc_pkg::APB_AW-1:0] a, input logic [acpc_pkg::APB_AW-1:0] r);
    return a == r;
  endfunction

  // Values 5 to 7 fall off the top and connect nothing.
  function automatic logic [NUM_PINS-1:0] chan_decode(input logic [acpc_pkg::CHSEL_W-1:0] c);
    logic [7:0] full;
    full = 8'h01 << c;
    return full[NUM_PINS-1:0];
  endfunction

  // Converter output is asynchronous to the core clock and is only captured once settled.
  logic [acpc_pkg::RESULT_W-1:0] data_s1_q;
  logic [acpc_pkg::RESULT_W-1:0] data_s2_q;

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      data_s1_q <= '0;
      data_s2_q <= '0;
    end
    else
    begin
      data_s1_q <= conv_data_in;
      data_s2_q <= data_s1_q;
    end
  end

  // APB slave: one wait state, so pready rises on the second access cycle.
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic acc_first;
  logic acc_done;
  logic wr_en;
  logic rd_done;
  logic [7:0] wb;
  logic [7:0] rdata;
  logic mapped;

  assign acc_first = psel_in & penable_in & ~pready_q;
  assign acc_done = psel_in & penable_in & pready_q;
  assign wr_en = acc_done & pwrite_in;
  assign rd_done = acc_done & ~pwrite_in;
  assign wb = pwdata_in[7:0];

  // Control and status state.
  logic [NUM_PINS-1:0] analog_only_q;
  logic [NUM_PINS-1:0] analog_only_d;
  logic ext_ref_en_q;
  logic ext_ref_en_d;
  logic [1:0] int_ref_level_q;
  logic [1:0] int_ref_level_d;
  logic conv_power_en_q;
  logic conv_power_en_d;
  logic chan_connect_en_q;
  logic chan_connect_en_d;
  logic [acpc_pkg::CHSEL_W-1:0] chan_sel_q;
  logic [acpc_pkg::CHSEL_W-1:0] chan_sel_d;
  logic [1:0] conv_clk_div_q;
  logic [1:0] conv_clk_div_d;
  logic resolution_sel_q;
  logic resolution_sel_d;
  logic conv_irq_en_q;
  logic conv_irq_en_d;
  logic conv_start_q;
  logic conv_start_d;
  logic eoc_q;
  logic eoc_d;
  logic conv_irq_flag_q;
  logic conv_irq_flag_d;
  logic [acpc_pkg::CHSEL_W-1:0] active_chan_q;
  logic [acpc_pkg::CHSEL_W-1:0] active_chan_d;
  logic [7:0] result_high_q;
  logic [7:0] result_high_d;
  logic [3:0] result_low_q;
  logic [3:0] result_low_d;
  logic start_req;
  logic seq_busy;
  logic seq_done;

  always_comb
  begin
    rdata = acpc_pkg::RESET_BYTE;
    mapped = 1'b1;
    if (addr_hit(paddr_in, acpc_pkg::ADDR_MODE))
    begin
      rdata[acpc_pkg::MODE_POWER_BIT] = conv_power_en_q;
      rdata[acpc_pkg::MODE_START_BIT] = conv_start_q;
      rdata[acpc_pkg::MODE_EOC_BIT] = eoc_q;
      rdata[acpc_pkg::MODE_CONNECT_BIT] = chan_connect_en_q;
      rdata[acpc_pkg::MODE_CHSEL_MSB:acpc_pkg::MODE_CHSEL_LSB] = chan_sel_q;
    end
    else if (addr_hit(paddr_in, acpc_pkg::ADDR_RESULT_HIGH))
    begin
      rdata = result_high_q;
    end
    else if (addr_hit(paddr_in, acpc_pkg::ADDR_RESULT_LOW))
    begin
      rdata[acpc_pkg::LOW_DIV1_BIT] = conv_clk_div_q[1];
      rdata[acpc_pkg::LOW_RES_BIT] = resolution_sel_q;
      rdata[acpc_pkg::LOW_DIV0_BIT] = conv_clk_div_q[0];
      rdata[acpc_pkg::LOW_NIB_MSB:0] = result_low_q;
    end
    else if (addr_hit(paddr_in, acpc_pkg::ADDR_REF))
    begin
      rdata[acpc_pkg::REF_EXT_BIT] = ext_ref_en_q;
      rdata[acpc_pkg::REF_LEVEL_MSB:0] = int_ref_level_q;
    end
    else if (addr_hit(paddr_in, acpc_pkg::ADDR_IRQ_STATUS))
    begin
      rdata[acpc_pkg::IRQ_CONV_BIT] = conv_irq_flag_q;
    end
    else if (addr_hit(paddr_in, acpc_pkg::ADDR_IRQ_MASK))
    begin
      rdata[acpc_pkg::IRQ_CONV_BIT] = conv_irq_en_q;
    end
    else if (!addr_hit(paddr_in, acpc_pkg::ADDR_ANALOG_ONLY))
    begin
      mapped = 1'b0;
    end
    // The analog-only register is write-only and reads as zero.
    pready_d = acc_first;
    pslverr_d = acc_first & ~mapped;
    prdata_d = prdata_q;
    if (acc_first)
    begin
      prdata_d = (pwrite_in || !mapped) ? 32'h0000_0000 : {24'h00_0000, rdata};
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // Register writes and conversion control.
  always_comb
  begin
    analog_only_d = analog_only_q;
    ext_ref_en_d = ext_ref_en_q;
    int_ref_level_d = int_ref_level_q;
    conv_power_en_d = conv_power_en_q;
    chan_connect_en_d = chan_connect_en_q;
    chan_sel_d = chan_sel_q;
    conv_clk_div_d = conv_clk_div_q;
    resolution_sel_d = resolution_sel_q;
    conv_irq_en_d = conv_irq_en_q;
    conv_start_d = conv_start_q;
    eoc_d = eoc_q;
    conv_irq_flag_d = conv_irq_flag_q;
    active_chan_d = active_chan_q;
    result_high_d = result_high_q;
    result_low_d = result_low_q;
    start_req = 1'b0;
    if (wr_en && addr_hit(paddr_in, acpc_pkg::ADDR_ANALOG_ONLY))
    begin
      analog_only_d = wb[NUM_PINS-1:0];
    end
    if (wr_en && addr_hit(paddr_in, acpc_pkg::ADDR_REF))
    begin
      ext_ref_en_d = wb[acpc_pkg::REF_EXT_BIT];
      int_ref_level_d = wb[acpc_pkg::REF_LEVEL_MSB:0];
    end
    if (wr_en && addr_hit(paddr_in, acpc_pkg::ADDR_RESULT_LOW))
    begin
      conv_clk_div_d = {wb[acpc_pkg::LOW_DIV1_BIT], wb[acpc_pkg::LOW_DIV0_BIT]};
      resolution_sel_d = wb[acpc_pkg::LOW_RES_BIT];
    end
    if (wr_en && addr_hit(paddr_in, acpc_pkg::ADDR_IRQ_MASK))
    begin
      conv_irq_en_d = wb[acpc_pkg::IRQ_CONV_BIT];
    end
    if (rd_done && addr_hit(paddr_in, acpc_pkg::ADDR_IRQ_STATUS))
    begin
      conv_irq_flag_d = 1'b0;
    end
    if (wr_en && addr_hit(paddr_in, acpc_pkg::ADDR_MODE))
    begin
      conv_power_en_d = wb[acpc_pkg::MODE_POWER_BIT];
      chan_connect_en_d = wb[acpc_pkg::MODE_CONNECT_BIT];
      chan_sel_d = wb[acpc_pkg::MODE_CHSEL_MSB:acpc_pkg::MODE_CHSEL_LSB];
      if (!wb[acpc_pkg::MODE_EOC_BIT])
      begin
        eoc_d = 1'b0;
      end
      // A start written while a conversion runs is ignored rather than restarting it.
      start_req = wb[acpc_pkg::MODE_START_BIT] & ~seq_busy;
    end
    if (seq_done)
    begin
      conv_start_d = 1'b0;
      eoc_d = 1'b1;
      conv_irq_flag_d = 1'b1;
      result_high_d = data_s2_q[acpc_pkg::RESULT_W-1:4];
      result_low_d = data_s2_q[3:0];
    end
    if (start_req)
    begin
      conv_start_d = 1'b1;
      eoc_d = 1'b0;
      active_chan_d = wb[acpc_pkg::MODE_CHSEL_MSB:acpc_pkg::MODE_CHSEL_LSB];
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      analog_only_q <= '0;
      ext_ref_en_q <= 1'b0;
      int_ref_level_q <= 2'h0;
      conv_power_en_q <= 1'b0;
      chan_connect_en_q <= 1'b0;
      chan_sel_q <= '0;
      conv_clk_div_q <= 2'h0;
      resolution_sel_q <= 1'b0;
      conv_irq_en_q <= 1'b0;
      conv_start_q <= 1'b0;
      eoc_q <= 1'b0;
      conv_irq_flag_q <= 1'b0;
      active_chan_q <= '0;
      result_high_q <= 8'h00;
      result_low_q <= 4'h0;
    end
    else
    begin
      analog_only_q <= analog_only_d;
      ext_ref_en_q <= ext_ref_en_d;
      int_ref_level_q <= int_ref_level_d;
      conv_power_en_q <= conv_power_en_d;
      chan_connect_en_q <= chan_connect_en_d;
      chan_sel_q <= chan_sel_d;
      conv_clk_div_q <= conv_clk_div_d;
      resolution_sel_q <= resolution_sel_d;
      conv_irq_en_q <= conv_irq_en_d;
      conv_start_q <= conv_start_d;
      eoc_q <= eoc_d;
      conv_irq_flag_q <= conv_irq_flag_d;
      active_chan_q <= active_chan_d;
      result_high_q <= result_high_d;
      result_low_q <= result_low_d;
    end
  end

  acpc_conv_seq u_seq (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .start_in(start_req),
    .clk_div_in(conv_clk_div_q),
    .res12_in(resolution_sel_q),
    .busy_out(seq_busy),
    .done_out(seq_done)
  );

  // Pin and interrupt outputs, all registered.
  logic [NUM_PINS-1:0] route_q;
  logic [NUM_PINS-1:0] route_d;
  logic [NUM_PINS-1:0] dig_en_q;
  logic [NUM_PINS-1:0] dig_en_d;
  logic ext_ref_q;
  logic [1:0] ref_level_q;
  logic power_q;
  logic sample_q;
  logic irq_q;
  logic irq_d;
  logic [15:0] vector_q;
  logic [15:0] vector_d;
  logic [acpc_pkg::CHSEL_W-1:0] route_chan;

  always_comb
  begin
    route_chan = seq_busy ? active_chan_q : chan_sel_q;
    route_d = '0;
    if (chan_connect_en_q)
    begin
      route_d = chan_decode(route_chan);
    end
    // Pin 0 cannot be a signal input while it carries the external reference.
    route_d[0] = route_d[0] & ~ext_ref_en_q;
    dig_en_d = ~analog_only_q;
    irq_d = conv_irq_flag_q & conv_irq_en_q;
    vector_d = irq_d ? acpc_pkg::IRQ_VECTOR : 16'h0000;
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      route_q <= '0;
      dig_en_q <= '1;
      ext_ref_q <= 1'b0;
      ref_level_q <= 2'h0;
      power_q <= 1'b0;
      sample_q <= 1'b0;
      irq_q <= 1'b0;
      vector_q <= 16'h0000;
    end
    else
    begin
      route_q <= route_d;
      dig_en_q <= dig_en_d;
      ext_ref_q <= ext_ref_en_q;
      ref_level_q <= int_ref_level_q;
      power_q <= conv_power_en_q;
      sample_q <= seq_busy;
      irq_q <= irq_d;
      vector_q <= vector_d;
    end
  end

  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign analog_route_out = route_q;
  assign port_digital_en_out = dig_en_q;
  assign ext_ref_route_out = ext_ref_q;
  assign int_ref_level_out = ref_level_q;
  assign conv_power_out = power_q;
  assign conv_sample_out = sample_q;
  assign irq_out = irq_q;
  assign irq_vector_out = vector_q;

  // Helper: measures each conversion against the length expected from its settings.
  logic [10:0] meas_q;
  logic [10:0] expect_q;

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meas_q <= 11'h000;
      expect_q <= 11'h000;
    end
    else if (start_req)
    begin
      meas_q <= 11'h000;
      expect_q <= acpc_pkg::conv_cycles(conv_clk_div_q, resolution_sel_q);
    end
    else
    begin
      meas_q <= 11'(meas_q + 11'h001);
    end
  end

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_start_write;
    start_req;
  endsequence

  sequence s_conv_end;
    seq_done ##1 (eoc_q && !conv_start_q);
  endsequence

  a_route_onehot: assert property ($onehot0(analog_route_out))
    else $error("More than one pin routed to the converter.");

  a_route_connect: assert property ((analog_route_out != '0) |-> $past(chan_connect_en_q))
    else $error("Pin routed without channel connect enable.");

  a_route_select: assert property ($past(chan_connect_en_q) && !$past(ext_ref_en_q)
    |-> analog_route_out == chan_decode($past(route_chan)))
    else $error("Routed pin does not match the channel value.");

  a_digital_off: assert property (port_digital_en_out == ~$past(analog_only_q))
    else $error("Digital enable does not follow analog-only setting.");

  a_start_eoc: assert property (s_start_write |=> (!eoc_q && conv_start_q))
    else $error("Start did not clear the end flag.");

  a_conv_done: assert property (seq_done && !start_req |-> s_conv_end ##0 conv_irq_flag_q)
    else $error("Conversion end did not clear start and set flags.");

  a_conv_length: assert property (seq_done |-> (meas_q == expect_q))
    else $error("Conversion length differs from the selected timing.");

  a_irq_level: assert property (##1 (irq_out == $past(conv_irq_flag_q && conv_irq_en_q)))
    else $error("Interrupt output does not follow flag and enable.");

  a_result_split: assert property (seq_done |=> (result_high_q == $past(data_s2_q[11:4]))
    && (result_low_q == $past(data_s2_q[3:0])))
    else $error("Result not split into high byte and low nibble.");

  a_ext_ref: assert property (##1 (ext_ref_route_out == $past(ext_ref_en_q)) && (!ext_ref_route_out || !route_q[0]))
    else $error("External reference pin handling is wrong.");

endmodule // acpc_top
